// ---- hdl/dpsdb_builder.sv ----
// Purpose: Builds and streams the 16-byte slave diagnostic block
// Assumes: Master request and error events are one-cycle pulses
// Notes:   Block goes out one byte per cycle; requests while busy merge into one waiting block
`timescale 1ns/10ps
// Notes on behaviour
// (RULE_01) Send the block on master request and whenever an error arises.
// (RULE_02) The bus master collects diagnostics arriving from slaves.
// (RULE_03) Bytes 0 to 5: three station status, master address, two id bytes.
// (RULE_04) Bytes 6 to 15 are device specific; 8 to 10 reserved zero.
// (RULE_05) Bytes 11 to 15 come from the user area the CPU writes.
// (RULE_06) Status 1: bits 0,5,7 zero; other bits map the slave flags.
// (RULE_07) Status 2: bit 2 one, bits 6,7 zero; other bits map flags.
// (RULE_08) Status 3: bits 0 to 6 zero, bit 7 diagnostic overflow.
// (RULE_09) Byte 3 is the address of the parametrizing master.
// (RULE_10) Byte 4 holds id high byte, byte 5 id low byte.
// (RULE_11) Byte 6 length and code, byte 7 the diagnostic message.
// (RULE_12) Byte 6 is fixed 00 001010, ten bytes, code zero.
// (RULE_13) Byte 7 carries one of the listed error or user-valid codes; the code passes ERR_CODE unchecked and sends 00 after reset or delete.
// (RULE_14) Rising valid bit in local status starts a report; bit 1 deletes.
// (RULE_15) A local status with valid and delete both set is ignored.
module dpsdb_builder #(
  parameter int USR_LEN = 5
) (
  input  wire logic                 CORE_CLK,
  input  wire logic                 RST_B,
  input  wire dpsdb_pkg::dpsdb_flags_t FLAGS,
  input  wire logic [7:0]           MASTER_ADDR,
  input  wire logic [15:0]          IDENT_NUM,
  input  wire logic                 DIAG_REQ,
  input  wire logic                 ERR_EVT,
  input  wire logic [7:0]           ERR_CODE,
  input  wire logic                 USR_WR,
  input  wire logic [2:0]           USR_IDX,
  input  wire logic [7:0]           USR_DATA,
  input  wire logic                 STAT_WR,
  input  wire logic [7:0]           STAT_DATA,
  output dpsdb_pkg::dpsdb_byte_t    DIAG_OUT,
  output logic                      BUSY,
  output logic [7:0]                DIAG_MSG
);
  import dpsdb_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_PREP, S_SEND} dpsdb_state_t;

  dpsdb_state_t state_ff, nxt_state;
  logic [3:0]   idx_ff, nxt_idx;
  logic         pend_ff;
  logic [7:0]   msg_ff;
  logic         stat_vld_ff;
  dpsdb_byte_t  out_ff;
  logic [7:0]   usr_rd;

  // Status byte accepted only when not both valid and delete
  // (RULE_15) reject both bits
  wire logic stat_ok   = STAT_WR && (STAT_DATA[1:0] != DPSDB_STAT_BOTH[1:0]);
  // (RULE_14) rising valid bit
  wire logic usr_start = stat_ok && STAT_DATA[0] && !stat_vld_ff;
  wire logic usr_del   = stat_ok && STAT_DATA[1];
  // (RULE_01) request or error
  wire logic trig      = DIAG_REQ || ERR_EVT || usr_start;

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      stat_vld_ff <= 1'b0;
    end else if (stat_ok) begin
      stat_vld_ff <= STAT_DATA[0];
    end
  end

  // (RULE_13) message code select, error wins over user valid
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      msg_ff <= DPSDB_RST_BYTE;
    end else if (ERR_EVT) begin
      msg_ff <= ERR_CODE;
    end else if (usr_start) begin
      msg_ff <= DPSDB_MSG_USR_OK;
    end else if (usr_del) begin
      msg_ff <= DPSDB_RST_BYTE;
    end
  end

  // Pending trigger, consumed by the start from idle; a trigger taken
  // from idle starts its block itself, so it must not also be kept
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pend_ff <= 1'b0;
    end else if (state_ff == S_IDLE) begin
      pend_ff <= 1'b0;
    end else if (trig) begin
      pend_ff <= 1'b1;
    end
  end

  wire logic start = (state_ff == S_IDLE) && (pend_ff || trig);

  // (RULE_05) user area write and read
  wire logic [2:0] rd_addr = 3'(idx_ff - 4'(DPSDB_USR_FIRST));

  dpsdb_usr_mem #(
    .DEPTH (USR_LEN),
    .AW    (3)
  ) u_mem (
    .CORE_CLK (CORE_CLK),
    .RST_B    (RST_B),
    .WR_EN    (USR_WR),
    .WR_ADDR  (USR_IDX),
    .WR_DATA  (USR_DATA),
    .RD_ADDR  (rd_addr),
    .RD_DATA  (usr_rd)
  );

  // Byte index lags by one because the user area read is registered
  logic [3:0] sidx_ff;

  // (RULE_06) station status 1
  wire logic [7:0] st1 = {1'b0, FLAGS.prm_fault, 1'b0, FLAGS.not_supp,
                          FLAGS.ext_diag, FLAGS.cfg_fault, FLAGS.not_ready, 1'b0};
  // (RULE_07) station status 2
  wire logic [7:0] st2 = {2'b00, FLAGS.sync, FLAGS.freeze, FLAGS.wd_on,
                          1'b1, FLAGS.stat_diag, FLAGS.prm_req};
  // (RULE_08) station status 3
  wire logic [7:0] st3 = {FLAGS.ovf, 7'h00};

  // (RULE_03) byte mux for the block
  logic [7:0] byte_sel;
  always_comb begin
    byte_sel = DPSDB_RST_BYTE;
    case (sidx_ff)
      4'h0:    byte_sel = st1;
      4'h1:    byte_sel = st2;
      4'h2:    byte_sel = st3;
      // (RULE_09) master address
      4'h3:    byte_sel = MASTER_ADDR;
      // (RULE_10) id high then low
      4'h4:    byte_sel = IDENT_NUM[15:8];
      4'h5:    byte_sel = IDENT_NUM[7:0];
      // (RULE_12) fixed length and code
      4'h6:    byte_sel = DPSDB_LEN_CODE;
      // (RULE_11) diagnostic message
      4'h7:    byte_sel = msg_ff;
      // (RULE_04) reserved bytes
      4'h8, 4'h9, 4'ha: byte_sel = DPSDB_RST_BYTE;
      default: byte_sel = usr_rd;
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_idx   = idx_ff;
    case (state_ff)
      S_IDLE: begin
        if (start) begin
          nxt_state = S_PREP;
          nxt_idx   = 4'h0;
        end
      end
      S_PREP: begin
        nxt_state = S_SEND;
        nxt_idx   = 4'h1;
      end
      S_SEND: begin
        if (sidx_ff == DPSDB_LAST_IDX) begin
          nxt_state = S_IDLE;
        end else begin
          nxt_idx = 4'(idx_ff + 4'h1);
        end
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_ff <= S_IDLE;
      idx_ff   <= 4'h0;
      sidx_ff  <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      idx_ff   <= nxt_idx;
      sidx_ff  <= idx_ff;
    end
  end

  wire logic sending = (state_ff == S_SEND);

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      out_ff   <= '0;
      BUSY     <= 1'b0;
      DIAG_MSG <= DPSDB_RST_BYTE;
    end else begin
      out_ff.valid <= sending;
      out_ff.last  <= sending && (sidx_ff == DPSDB_LAST_IDX);
      out_ff.data  <= sending ? byte_sel : DPSDB_RST_BYTE;
      BUSY         <= (nxt_state != S_IDLE);
      DIAG_MSG     <= msg_ff;
    end
  end

  assign DIAG_OUT = out_ff;

  a_req_starts: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE_01
    (DIAG_REQ && state_ff == S_IDLE) |-> ##3 DIAG_OUT.valid)
    else $error("request did not start the block");
  a_stat1_fixed: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE_06
    (DIAG_OUT.valid && $past(sidx_ff) == 4'h0) |-> (DIAG_OUT.data[7] == 1'b0
    && DIAG_OUT.data[5] == 1'b0 && DIAG_OUT.data[0] == 1'b0))
    else $error("station status 1 fixed bits wrong");
  a_stat2_fixed: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE_07
    (DIAG_OUT.valid && $past(sidx_ff) == 4'h1) |-> (DIAG_OUT.data[2] && !DIAG_OUT.data[7]))
    else $error("station status 2 fixed bits wrong");
  a_stat3_low: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE_08
    (DIAG_OUT.valid && $past(sidx_ff) == 4'h2) |-> (DIAG_OUT.data[6:0] == 7'h00))
    else $error("station status 3 reserved bits set");
  a_len_code: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE_12
    (DIAG_OUT.valid && $past(sidx_ff) == 4'h6) |-> (DIAG_OUT.data == 8'h0a))
    else $error("length byte wrong");
  a_reserved_zero: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE_04
    (DIAG_OUT.valid && $past(sidx_ff) inside {4'h8, 4'h9, 4'ha}) |-> (DIAG_OUT.data == 8'h00))
    else $error("reserved byte not zero");
  a_block_length: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE_03
    (DIAG_OUT.valid && !$past(DIAG_OUT.valid)) |-> DIAG_OUT.valid[*8] ##8 DIAG_OUT.last)
    else $error("block is not sixteen bytes");
  a_usr_valid_msg: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE_14
    (usr_start && !ERR_EVT) |=> (msg_ff == 8'h40))
    else $error("user start did not set valid code");
  a_both_ignored: assert property (@(posedge CORE_CLK) disable iff (!RST_B) // RULE_15
    (STAT_WR && STAT_DATA[1:0] == 2'b11) |=> $stable(stat_vld_ff))
    else $error("status with both bits was taken");

  c_req: cover property (@(posedge CORE_CLK) disable iff (!RST_B) DIAG_REQ ##[1:20] DIAG_OUT.last);
  c_err: cover property (@(posedge CORE_CLK) disable iff (!RST_B) ERR_EVT ##[1:20] DIAG_OUT.last);
  c_usr: cover property (@(posedge CORE_CLK) disable iff (!RST_B) usr_start ##[1:20] DIAG_OUT.last);
endmodule

// ---- inc/dpsdb_pkg.sv ----
// Purpose: Constants and types for the slave diagnostic block builder
// Assumes: 16-byte diagnostic block, byte 0 sent first
// Notes:   Message codes are the device-specific byte 7 values
package dpsdb_pkg;
  localparam int        DPSDB_BLK_LEN   = 16;
  localparam int        DPSDB_USR_LEN   = 5;
  localparam int        DPSDB_USR_FIRST = 11;
  localparam logic [3:0] DPSDB_LAST_IDX = 4'hf;
  localparam logic [7:0] DPSDB_LEN_CODE = 8'h0a;
  localparam logic [7:0] DPSDB_MSG_PRM_LEN = 8'h12;
  localparam logic [7:0] DPSDB_MSG_CFG_LEN = 8'h13;
  localparam logic [7:0] DPSDB_MSG_CFG_ENT = 8'h14;
  localparam logic [7:0] DPSDB_MSG_BUF_CALC = 8'h15;
  localparam logic [7:0] DPSDB_MSG_NO_CFG   = 8'h16;
  localparam logic [7:0] DPSDB_MSG_MISMATCH = 8'h17;
  localparam logic [7:0] DPSDB_MSG_USR_OK   = 8'h40;
  localparam logic [7:0] DPSDB_RST_BYTE     = 8'h00;
  localparam logic [7:0] DPSDB_STAT_BOTH    = 8'h03;

  // Slave status flags feeding the station status bytes
  typedef struct packed {
    logic not_ready;
    logic cfg_fault;
    logic ext_diag;
    logic not_supp;
    logic prm_fault;
    logic prm_req;
    logic stat_diag;
    logic wd_on;
    logic freeze;
    logic sync;
    logic ovf;
  } dpsdb_flags_t;

  // One byte of the outgoing block
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } dpsdb_byte_t;
endpackage

// ---- hdl/dpsdb_usr_mem.sv ----
// Purpose: Small register file holding the user diagnostic bytes
// Assumes: One write port, one registered read port
// Notes:   Read data lag the address by one cycle
`timescale 1ns/10ps
module dpsdb_usr_mem #(
  parameter int DEPTH = 5,
  parameter int AW    = 3
) (
  input  wire logic          CORE_CLK,
  input  wire logic          RST_B,
  input  wire logic          WR_EN,
  input  wire logic [AW-1:0] WR_ADDR,
  input  wire logic [7:0]    WR_DATA,
  input  wire logic [AW-1:0] RD_ADDR,
  output logic      [7:0]    RD_DATA
);
  import dpsdb_pkg::*;
  logic [7:0] mem_ff [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_cell
      always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
          mem_ff[g] <= DPSDB_RST_BYTE;
        end else if (WR_EN && (WR_ADDR == AW'(g))) begin
          mem_ff[g] <= WR_DATA;
        end
      end
    end
  endgenerate

  wire logic [7:0] rd_sel = (int'(RD_ADDR) < DEPTH) ? mem_ff[RD_ADDR] : DPSDB_RST_BYTE;

  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      RD_DATA <= DPSDB_RST_BYTE;
    end else begin
      RD_DATA <= rd_sel;
    end
  end
endmodule

// ---- tb/dpsdb_master_mdl.sv ----
// Purpose: Bus master model polling the slave for its diagnostic block
// Assumes: One-cycle request pulse, block ends on the byte marked last
// Notes:   Counts every valid byte marked last; the bytes before it are not checked
`timescale 1ns/10ps
module dpsdb_master_mdl (
  input  wire logic                   CORE_CLK,
  input  wire logic                   RST_B,
  input  wire logic                   POLL,
  input  wire dpsdb_pkg::dpsdb_byte_t DIAG_OUT,
  output logic                        DIAG_REQ,
  output int                          BLK_CNT
);
  import dpsdb_pkg::*;
  // Launched off the falling edge, clear of the sampling edge
  always @(negedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      DIAG_REQ <= 1'b0;
    end else begin
      DIAG_REQ <= POLL;
    end
  end
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      BLK_CNT <= 0;
    end else if (DIAG_OUT.valid === 1'b1 && DIAG_OUT.last === 1'b1) begin
      BLK_CNT <= BLK_CNT + 1;
    end
  end
endmodule

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the diagnostic block builder
// Assumes: Inputs change on the falling edge only
// Notes:   Expected bytes queued by the driver, popped by the monitor
`timescale 1ns/10ps
module testbench;
  import dpsdb_pkg::*;
  logic         core_clk = 1'b0;
  logic         rst_b = 1'b0;
  dpsdb_flags_t flags = '0;
  logic [7:0]   master_addr = 8'h00;
  logic [15:0]  ident_num = 16'h0000;
  logic         err_evt = 1'b0;
  logic [7:0]   err_code = 8'h00;
  logic         usr_wr = 1'b0;
  logic [2:0]   usr_idx = 3'h0;
  logic [7:0]   usr_data = 8'h00;
  logic         stat_wr = 1'b0;
  logic [7:0]   stat_data = 8'h00;
  logic         poll = 1'b0;
  logic         diag_req;
  logic         busy;
  logic [7:0]   diag_msg;
  dpsdb_byte_t  diag_out;
  int           blk_cnt;
  int           err_count = 0;
  int           comparisons = 0;
  int           nblk = 0;
  logic [8:0]   exp_q[$];
  logic [7:0]   usr[5];
  logic [7:0]   codes[6] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17};

  always #5 core_clk = ~core_clk;

  dpsdb_builder #(.USR_LEN(5)) DUT (.CORE_CLK(core_clk), .RST_B(rst_b), .FLAGS(flags),
    .MASTER_ADDR(master_addr), .IDENT_NUM(ident_num), .DIAG_REQ(diag_req),
    .ERR_EVT(err_evt), .ERR_CODE(err_code), .USR_WR(usr_wr), .USR_IDX(usr_idx),
    .USR_DATA(usr_data), .STAT_WR(stat_wr), .STAT_DATA(stat_data),
    .DIAG_OUT(diag_out), .BUSY(busy), .DIAG_MSG(diag_msg));
  dpsdb_master_mdl MST (.CORE_CLK(core_clk), .RST_B(rst_b), .POLL(poll),
    .DIAG_OUT(diag_out), .DIAG_REQ(diag_req), .BLK_CNT(blk_cnt));

  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic note(input logic [7:0] code);
    logic [7:0] b[16];
    b = '{default: 8'h00};
    b[0] = {1'b0, flags.prm_fault, 1'b0, flags.not_supp, flags.ext_diag,
            flags.cfg_fault, flags.not_ready, 1'b0};
    b[1] = {2'b00, flags.sync, flags.freeze, flags.wd_on, 1'b1, flags.stat_diag, flags.prm_req};
    b[2] = {flags.ovf, 7'h00};
    b[3] = master_addr;
    b[4] = ident_num[15:8];
    b[5] = ident_num[7:0];
    b[6] = 8'h0a;
    b[7] = code;
    for (int i = 0; i < 5; i++) b[11+i] = usr[i];
    for (int i = 0; i < 16; i++) exp_q.push_back({i == 15, b[i]});
  endtask

  // Kind 0 error, 1 poll, 2 status write, 3 poll held for four cycles
  task automatic trig(input int kind, input logic [7:0] data, input logic [7:0] code,
                      input int n);
    int k;
    @(negedge core_clk);
    flags <= dpsdb_flags_t'(11'($urandom));
    master_addr <= 8'($urandom);
    ident_num <= 16'($urandom);
    @(negedge core_clk);
    repeat (n) note(code);
    nblk += n;
    poll <= (kind == 1 || kind == 3);
    err_evt <= (kind == 0);
    stat_wr <= (kind == 2);
    err_code <= data;
    stat_data <= data;
    @(negedge core_clk);
    poll <= (kind == 3);
    err_evt <= 1'b0;
    stat_wr <= 1'b0;
    for (k = 0; k < 3; k++) @(negedge core_clk);
    check("busy", {8'h00, busy}, {8'h00, n > 0});
    poll <= 1'b0;
    // Busy would already stand if a refused write had started a block
    for (k = 0; k < 90 && !(blk_cnt == nblk && busy === 1'b0); k++) @(negedge core_clk);
    check("blocks", 9'(blk_cnt), 9'(nblk));
    check("message", {1'b0, diag_msg}, {1'b0, code});
  endtask

  always @(negedge core_clk) begin
    if (diag_out.valid === 1'b1) begin
      if (exp_q.size() == 0) check("stray byte", 9'h1ff, 9'h000);
      else check("byte", {diag_out.last, diag_out.data}, exp_q.pop_front());
    end
  end

  initial begin
    void'($urandom(43));
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      @(negedge core_clk);
      usr[i] = 8'($urandom);
      usr_wr <= 1'b1;
      usr_idx <= 3'(i);
      usr_data <= usr[i];
    end
    @(negedge core_clk);
    usr_wr <= 1'b0;
    trig(2, 8'h01, 8'h40, 1);
    foreach (codes[i]) trig(0, codes[i], codes[i], 1);
    trig(2, 8'h00, 8'h17, 0);
    trig(2, 8'h03, 8'h17, 0);
    trig(2, 8'h02, 8'h00, 0);
    trig(1, 8'h00, 8'h00, 1);
    trig(3, 8'h00, 8'h00, 2);
    finish_test();
  end

  initial begin
    #50us;
    err_count++;
    finish_test();
  end
endmodule
